// ===== rtl/clock_select_startup_sequencer.sv
// clock source decode, start-up sequencing and clock domain gating
module clock_select_startup_sequencer (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // fuses
  input wire logic [3:0] clock_source_fuses_in,
  input wire logic [1:0] startup_time_fuses_in,
  input wire logic divide_by_eight_fuse_in,
  // reset sources and oscillator ticks
  input wire logic ext_reset_active_in,
  input wire logic wdt_osc_tick_in,
  input wire logic osc_tick_in,
  // sleep control
  input wire logic sleep_wake_in,
  input wire logic core_clock_stop_in,
  input wire logic peripheral_clock_stop_in,
  input wire logic converter_clock_stop_in,
  input wire logic async_timer_clock_stop_in,
  input wire logic async_timer_tick_in,
  input wire logic ext_irq_level_in,
  // status
  output logic internal_reset_out,
  output logic [2:0] clock_source_out,
  output logic [2:0] crystal_range_out,
  output logic fuse_reserved_out,
  // clock enables
  output logic core_clock_out,
  output logic program_memory_clock_out,
  output logic peripheral_clock_out,
  output logic converter_clock_out,
  output logic async_timer_clock_out,
  output logic ext_irq_wake_out
);

  // ==========================================================
  // fuse capture after reset release
  logic [3:0] cks_r;
  logic [1:0] sut_r;
  logic div_fuse_r;
  logic fuses_loaded_r;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cks_r <= clk_seq_pkg::CLOCK_SOURCE_DEFAULT;
      sut_r <= clk_seq_pkg::STARTUP_TIME_DEFAULT;
      div_fuse_r <= clk_seq_pkg::DIVIDE_FUSE_DEFAULT;
      fuses_loaded_r <= 1'b0;
    end else if (!fuses_loaded_r) begin
      cks_r <= clock_source_fuses_in;
      sut_r <= startup_time_fuses_in;
      div_fuse_r <= divide_by_eight_fuse_in;
      fuses_loaded_r <= 1'b1;
    end
  end

  // ==========================================================
  // source decode
  clk_seq_pkg::clk_src_e src;
  assign src = cks_r[3] ? clk_seq_pkg::SRC_LOW_POWER_XTAL :
               (cks_r[3:1] == 3'h3) ? clk_seq_pkg::SRC_FULL_SWING_XTAL :
               (cks_r[3:1] == 3'h2) ? clk_seq_pkg::SRC_LOW_FREQ_XTAL :
               (cks_r == clk_seq_pkg::CODE_RC_128K) ? clk_seq_pkg::SRC_RC_128K :
               (cks_r == clk_seq_pkg::CODE_RC_CAL) ? clk_seq_pkg::SRC_RC_CAL :
               (cks_r == clk_seq_pkg::CODE_EXTERNAL) ? clk_seq_pkg::SRC_EXTERNAL :
               clk_seq_pkg::SRC_RESERVED;

  logic [2:0] range_w;
  assign range_w = (src == clk_seq_pkg::SRC_LOW_POWER_XTAL) ? cks_r[3:1] : 3'h0;

  logic div8_w;
  assign div8_w = (div_fuse_r == clk_seq_pkg::FUSE_PROGRAMMED);

  // ==========================================================
  // delay tables
  logic [clk_seq_pkg::CNT_W-1:0] tout_w;
  logic [clk_seq_pkg::CNT_W-1:0] osc_reset_w;
  logic [clk_seq_pkg::CNT_W-1:0] osc_wake_w;

  always_comb begin
    tout_w = clk_seq_pkg::TOUT_NONE;
    osc_reset_w = clk_seq_pkg::OSC_EXT;
    osc_wake_w = clk_seq_pkg::OSC_EXT;
    if (src == clk_seq_pkg::SRC_LOW_POWER_XTAL ||
        src == clk_seq_pkg::SRC_FULL_SWING_XTAL) begin
      osc_reset_w = clk_seq_pkg::OSC_14;
      unique case ({cks_r[0], sut_r})
        3'b000: begin
          osc_wake_w = clk_seq_pkg::OSC_258;
          tout_w = clk_seq_pkg::TOUT_SHORT;
        end
        3'b001: begin
          osc_wake_w = clk_seq_pkg::OSC_258;
          tout_w = clk_seq_pkg::TOUT_LONG;
        end
        3'b010: begin
          osc_wake_w = clk_seq_pkg::OSC_1K;
          tout_w = clk_seq_pkg::TOUT_NONE;
        end
        3'b011: begin
          osc_wake_w = clk_seq_pkg::OSC_1K;
          tout_w = clk_seq_pkg::TOUT_SHORT;
        end
        3'b100: begin
          osc_wake_w = clk_seq_pkg::OSC_1K;
          tout_w = clk_seq_pkg::TOUT_LONG;
        end
        3'b101: begin
          osc_wake_w = clk_seq_pkg::OSC_16K;
          tout_w = clk_seq_pkg::TOUT_NONE;
        end
        3'b110: begin
          osc_wake_w = clk_seq_pkg::OSC_16K;
          tout_w = clk_seq_pkg::TOUT_SHORT;
        end
        3'b111: begin
          osc_wake_w = clk_seq_pkg::OSC_16K;
          tout_w = clk_seq_pkg::TOUT_LONG;
        end
      endcase
      // the 14 extra cycles precede the wake count after reset
      osc_reset_w = osc_wake_w + clk_seq_pkg::OSC_14;
    end else begin
      unique case (sut_r)
        2'b00: tout_w = clk_seq_pkg::TOUT_NONE;
        2'b01: tout_w = clk_seq_pkg::TOUT_SHORT;
        default: tout_w = clk_seq_pkg::TOUT_LONG;
      endcase
      if (src == clk_seq_pkg::SRC_LOW_FREQ_XTAL) begin
        osc_wake_w = cks_r[0] ? clk_seq_pkg::OSC_32K : clk_seq_pkg::OSC_1K;
        osc_reset_w = clk_seq_pkg::OSC_4;
      end else begin
        osc_wake_w = clk_seq_pkg::OSC_EXT;
        osc_reset_w = clk_seq_pkg::OSC_EXT;
      end
    end
  end

  // ==========================================================
  // start-up sequencer
  clk_seq_pkg::seq_state_e state_r;
  clk_seq_pkg::seq_state_e state_nxt;
  logic [clk_seq_pkg::CNT_W-1:0] cnt_r;
  logic [clk_seq_pkg::CNT_W-1:0] cnt_nxt;
  logic from_wake_r;
  logic from_wake_nxt;
  logic tout_done_w;
  logic osc_done_w;
  logic [clk_seq_pkg::CNT_W-1:0] osc_target_w;

  assign osc_target_w = from_wake_r ? osc_wake_w : osc_reset_w;
  assign tout_done_w = (cnt_r >= tout_w);
  assign osc_done_w = (cnt_r >= osc_target_w);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    from_wake_nxt = from_wake_r;
    unique case (state_r)
      clk_seq_pkg::ST_HOLD: begin
        cnt_nxt = '0;
        from_wake_nxt = 1'b0;
        if (fuses_loaded_r && !ext_reset_active_in) begin
          state_nxt = clk_seq_pkg::ST_TIMEOUT;
        end
      end
      clk_seq_pkg::ST_TIMEOUT: begin
        if (tout_done_w) begin
          state_nxt = clk_seq_pkg::ST_OSC;
          cnt_nxt = '0;
        end else if (wdt_osc_tick_in) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      clk_seq_pkg::ST_OSC: begin
        if (osc_done_w) begin
          state_nxt = clk_seq_pkg::ST_RUN;
        end else if (osc_tick_in) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      clk_seq_pkg::ST_RUN: begin
        if (sleep_wake_in) begin
          state_nxt = clk_seq_pkg::ST_OSC;
          cnt_nxt = '0;
          from_wake_nxt = 1'b1;
        end
      end
    endcase
    if (ext_reset_active_in) begin
      state_nxt = clk_seq_pkg::ST_HOLD;
      cnt_nxt = '0;
      from_wake_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= clk_seq_pkg::ST_HOLD;
      cnt_r <= '0;
      from_wake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      from_wake_r <= from_wake_nxt;
    end
  end

  // ==========================================================
  // clock enables
  logic run_w;
  logic sys_tick_w;
  assign run_w = (state_r == clk_seq_pkg::ST_RUN);

  clk_cfg_if cfg ();
  assign cfg.div8_en = div8_w;
  assign cfg.run = run_w;

  clk_div8 u_div (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .cfg(cfg),
    .tick_out(sys_tick_w)
  );

  logic core_r;
  logic periph_r;
  logic conv_r;
  logic asy_r;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_r <= 1'b0;
      periph_r <= 1'b0;
      conv_r <= 1'b0;
      asy_r <= 1'b0;
    end else begin
      core_r <= sys_tick_w & ~core_clock_stop_in;
      periph_r <= sys_tick_w & ~peripheral_clock_stop_in;
      conv_r <= sys_tick_w & ~converter_clock_stop_in;
      asy_r <= async_timer_tick_in & ~async_timer_clock_stop_in;
    end
  end

  assign internal_reset_out = ~run_w;
  assign clock_source_out = src;
  assign crystal_range_out = range_w;
  assign fuse_reserved_out = (cks_r == clk_seq_pkg::CODE_RESERVED);
  assign core_clock_out = core_r;
  assign program_memory_clock_out = core_r;
  assign peripheral_clock_out = periph_r;
  assign converter_clock_out = conv_r;
  assign async_timer_clock_out = asy_r;
  assign ext_irq_wake_out = ext_irq_level_in;

endmodule : clock_select_startup_sequencer

// ===== rtl/clk_seq_pkg.sv
// constants and types for the clock select and start-up sequencer
// What this block does
// - decode four fuse bits into clock source
// - fuse bit one means unprogrammed
// - default fuses: RC 8 MHz, start-up 10, divide
// - programmed divide fuse divides clock by eight
// - hold internal reset for extra time-out
// - time-out counts watchdog cycles: 0, 512, 8192
// - ripple counter holds reset for oscillator cycles
// - oscillator count from 4 to 32K cycles
// - reset: time-out then count; wake: count only
// - low power crystal upper bits select range
// - low bit and start-up field select delays
// - low bit zero: 258 or 1K wake counts
// - low bit one: 1K or 16K wake counts
// - converter clock gated independently of core clocks
// - async timer clock runs in own domain
// - some external interrupts detected without peripheral clock
// - program memory clock gated with core clock
package clk_seq_pkg;

  // ==========================================================
  // clock sources
  typedef enum logic [2:0] {
    SRC_LOW_POWER_XTAL = 3'h0,
    SRC_FULL_SWING_XTAL = 3'h1,
    SRC_LOW_FREQ_XTAL = 3'h2,
    SRC_RC_128K = 3'h3,
    SRC_RC_CAL = 3'h4,
    SRC_EXTERNAL = 3'h5,
    SRC_RESERVED = 3'h6
  } clk_src_e;

  // ==========================================================
  // fuse reset values (0 = programmed)
  localparam logic [3:0] CLOCK_SOURCE_DEFAULT = 4'h2;
  localparam logic [1:0] STARTUP_TIME_DEFAULT = 2'h2;
  localparam logic DIVIDE_FUSE_DEFAULT = 1'b0;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic [3:0] CODE_EXTERNAL = 4'h0;
  localparam logic [3:0] CODE_RESERVED = 4'h1;
  localparam logic [3:0] CODE_RC_CAL = 4'h2;
  localparam logic [3:0] CODE_RC_128K = 4'h3;

  // ==========================================================
  // low power crystal ranges (upper three fuse bits)
  localparam logic [2:0] RANGE_0P4_0P9 = 3'h4;
  localparam logic [2:0] RANGE_0P9_3P0 = 3'h5;
  localparam logic [2:0] RANGE_3P0_8P0 = 3'h6;
  localparam logic [2:0] RANGE_8P0_16P0 = 3'h7;

  // ==========================================================
  // counts
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] TOUT_NONE = 16'h0000;
  localparam logic [CNT_W-1:0] TOUT_SHORT = 16'h0200;
  localparam logic [CNT_W-1:0] TOUT_LONG = 16'h2000;
  localparam logic [CNT_W-1:0] OSC_EXT = 16'h0006;
  localparam logic [CNT_W-1:0] OSC_4 = 16'h0004;
  localparam logic [CNT_W-1:0] OSC_14 = 16'h000E;
  localparam logic [CNT_W-1:0] OSC_258 = 16'h0102;
  localparam logic [CNT_W-1:0] OSC_1K = 16'h0400;
  localparam logic [CNT_W-1:0] OSC_16K = 16'h4000;
  localparam logic [CNT_W-1:0] OSC_32K = 16'h8000;
  localparam logic [2:0] DIV_LAST = 3'h3;

  // ==========================================================
  // sequencer states, gray along the path
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_TIMEOUT = 2'b01,
    ST_OSC = 2'b11,
    ST_RUN = 2'b10
  } seq_state_e;

endpackage : clk_seq_pkg

// ===== rtl/clk_cfg_if.sv
// decoded fuse settings passed from sequencer to divider
interface clk_cfg_if;
  logic div8_en;
  logic run;
  modport src (output div8_en, output run);
  modport dst (input div8_en, input run);
endinterface : clk_cfg_if

// ===== rtl/clk_div8.sv
// divide-by-eight clock enable generator
module clk_div8 (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // configuration
  clk_cfg_if.dst cfg,
  // tick out
  output logic tick_out
);
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic tick_r;
  logic tick_nxt;

  assign div_nxt = cfg.run ? div_r + 3'h1 : 3'h0;
  assign tick_nxt = cfg.run & (~cfg.div8_en | (div_r == clk_seq_pkg::DIV_LAST + 3'h4));

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;
endmodule : clk_div8

// ===== testbench/clk_seq_assertions.sv
// port checker for the clock select and start-up sequencer
module clk_seq_assertions (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // watched inputs
  input wire logic ext_reset_active_in,
  input wire logic osc_tick_in,
  input wire logic core_clock_stop_in,
  input wire logic divide_by_eight_fuse_in,
  input wire logic ext_irq_level_in,
  // watched outputs
  input wire logic internal_reset_out,
  input wire logic [2:0] clock_source_out,
  input wire logic [2:0] crystal_range_out,
  input wire logic fuse_reserved_out,
  input wire logic core_clock_out,
  input wire logic program_memory_clock_out,
  input wire logic ext_irq_wake_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================================
  // sequencing
  a_source_holds_reset: assert property (ext_reset_active_in |=> internal_reset_out)
    else $error("internal reset low after reset source");
  a_release_after_osc: assert property ($fell(internal_reset_out) |->
    $past(osc_tick_in) || $past(osc_tick_in, 2) || $past(osc_tick_in, 3))
    else $error("reset released without oscillator tick");
  a_release_no_source: assert property ($fell(internal_reset_out) |->
    !$past(ext_reset_active_in)) else $error("reset released while source active");
  a_core_quiet_reset: assert property (internal_reset_out[*3] |-> !core_clock_out)
    else $error("core clock runs in reset");
  // ==========================================================
  // clock domains
  a_flash_with_core: assert property (program_memory_clock_out == core_clock_out)
    else $error("program memory clock apart from core");
  a_core_stop_quiet: assert property (core_clock_stop_in[*2] |-> !core_clock_out)
    else $error("core clock runs while stopped");
  a_div_spacing: assert property (core_clock_out && !divide_by_eight_fuse_in |=>
    !core_clock_out[*7]) else $error("divided core clock too fast");
  a_irq_async: assert property (ext_irq_wake_out == ext_irq_level_in)
    else $error("interrupt wake not passed through");
  // ==========================================================
  // decode
  a_reserved_code: assert property (fuse_reserved_out |->
    clock_source_out == clk_seq_pkg::SRC_RESERVED) else $error("reserved flag mismatch");
  a_range_lp_only: assert property (clock_source_out != clk_seq_pkg::SRC_LOW_POWER_XTAL |->
    crystal_range_out == 3'h0) else $error("range outside low power mode");
endmodule : clk_seq_assertions

bind clock_select_startup_sequencer clk_seq_assertions i_chk (.ref_clk_in, .rstn_in,
  .ext_reset_active_in, .osc_tick_in, .core_clock_stop_in, .divide_by_eight_fuse_in,
  .ext_irq_level_in, .internal_reset_out, .clock_source_out, .crystal_range_out,
  .fuse_reserved_out, .core_clock_out, .program_memory_clock_out, .ext_irq_wake_out);

// ===== testbench/osc_source_model.sv
// selected oscillator and watchdog oscillator tick source
module osc_source_model (
  // clock
  input wire logic clk_in,
  // ticks
  output logic osc_tick_out,
  output logic wdt_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    osc_tick_out = 1'b0;
    wdt_tick_out = 1'b0;
  end
  task automatic pulses(input logic wdt, input int n);
    repeat (n) begin
      @(posedge clk_in);
      if (wdt) begin
        wdt_tick_out <= 1'b1;
      end else begin
        osc_tick_out <= 1'b1;
      end
      @(posedge clk_in);
      wdt_tick_out <= 1'b0;
      osc_tick_out <= 1'b0;
    end
  endtask : pulses
endmodule : osc_source_model

// ===== testbench/tb_clock_select_startup_sequencer.sv
// testbench for the clock select and start-up sequencer
module tb_clock_select_startup_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] clock_source_fuses_in = 4'h2;
  logic [1:0] startup_time_fuses_in = 2'h2;
  logic divide_by_eight_fuse_in = 1'b0;
  logic ext_reset_active_in = 1'b0;
  logic sleep_wake_in = 1'b0;
  logic core_clock_stop_in = 1'b0;
  logic peripheral_clock_stop_in = 1'b0;
  logic converter_clock_stop_in = 1'b0;
  logic async_timer_clock_stop_in = 1'b0;
  logic async_timer_tick_in = 1'b0;
  logic ext_irq_level_in = 1'b0;
  logic wdt_osc_tick_in;
  logic osc_tick_in;
  logic internal_reset_out;
  logic [2:0] clock_source_out;
  logic [2:0] crystal_range_out;
  logic fuse_reserved_out;
  logic core_clock_out;
  logic program_memory_clock_out;
  logic peripheral_clock_out;
  logic converter_clock_out;
  logic async_timer_clock_out;
  logic ext_irq_wake_out;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n_core;
  int n_conv;
  int n_per;
  int n_asy;

  always #10 ref_clk_in = ~ref_clk_in;

  clock_select_startup_sequencer i_dut (.ref_clk_in, .rstn_in, .clock_source_fuses_in,
    .startup_time_fuses_in, .divide_by_eight_fuse_in, .ext_reset_active_in,
    .wdt_osc_tick_in, .osc_tick_in, .sleep_wake_in, .core_clock_stop_in,
    .peripheral_clock_stop_in, .converter_clock_stop_in, .async_timer_clock_stop_in,
    .async_timer_tick_in, .ext_irq_level_in, .internal_reset_out, .clock_source_out,
    .crystal_range_out, .fuse_reserved_out, .core_clock_out, .program_memory_clock_out,
    .peripheral_clock_out, .converter_clock_out, .async_timer_clock_out, .ext_irq_wake_out);
  osc_source_model i_osc (.clk_in(ref_clk_in), .osc_tick_out(osc_tick_in),
    .wdt_tick_out(wdt_osc_tick_in));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    // settle before anyone samples outputs
    @(negedge ref_clk_in);
  endtask : cyc
  function automatic logic [2:0] exp_src(input logic [3:0] c);
    if (c[3]) return 3'h0;
    if (c[2:1] == 2'h3) return 3'h1;
    if (c[2:1] == 2'h2) return 3'h2;
    if (c == 4'h3) return 3'h3;
    if (c == 4'h2) return 3'h4;
    return (c == 4'h0) ? 3'h5 : 3'h6;
  endfunction : exp_src
  task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic d);
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    clock_source_fuses_in <= c;
    startup_time_fuses_in <= s;
    divide_by_eight_fuse_in <= d;
    cyc(16);
    check(clock_source_out, 3'h4);
    @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    cyc(3);
  endtask : boot
  task automatic await_osc(input int n);
    i_osc.pulses(1'b0, n - 1);
    cyc(3);
    check(internal_reset_out, 1'b1);
    i_osc.pulses(1'b0, 1);
    cyc(3);
    check(internal_reset_out, 1'b0);
  endtask : await_osc
  task automatic start(input logic [3:0] c, input logic [1:0] s, input logic d,
                       input int t, input int n);
    boot(c, s, d);
    if (t > 0) begin
      i_osc.pulses(1'b0, 8);
      i_osc.pulses(1'b1, t - 1);
      cyc(2);
      check(internal_reset_out, 1'b1);
      i_osc.pulses(1'b1, 1);
      cyc(2);
    end
    await_osc(n);
  endtask : start
  task automatic count(input int n);
    n_core = 0;
    n_conv = 0;
    n_asy = 0;
    n_per = 0;
    repeat (n) begin
      @(negedge ref_clk_in);
      n_core += core_clock_out;
      n_per += peripheral_clock_out;
      n_conv += converter_clock_out;
      n_asy += async_timer_clock_out;
    end
  endtask : count

  // ==========================================================
  // watchdog on the run
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    for (int i = 0; i < 16; i++) begin
      boot(i[3:0], 2'h0, 1'b1);
      check(clock_source_out, exp_src(i[3:0]));
      check(crystal_range_out, i[3] ? i[3:1] : 3'h0);
      check(fuse_reserved_out, i == 1);
    end
    start(4'h2, 2'h2, 1'b0, 8192, 6);
    count(64);
    check(n_core, 8);
    @(posedge ref_clk_in);
    core_clock_stop_in <= 1'b1;
    peripheral_clock_stop_in <= 1'b1;
    async_timer_tick_in <= 1'b1;
    ext_irq_level_in <= 1'b1;
    cyc(2);
    count(64);
    check(n_core, 0);
    check(n_per, 0);
    check(n_conv, 8);
    check(n_asy != 0, 1'b1);
    check(ext_irq_wake_out, 1'b1);
    @(posedge ref_clk_in);
    core_clock_stop_in <= 1'b0;
    peripheral_clock_stop_in <= 1'b0;
    boot(4'h3, 2'h1, 1'b1);
    i_osc.pulses(1'b1, 512);
    cyc(2);
    i_osc.pulses(1'b0, 3);
    @(posedge ref_clk_in);
    ext_reset_active_in <= 1'b1;
    cyc(2);
    ext_reset_active_in <= 1'b0;
    cyc(2);
    i_osc.pulses(1'b0, 6);
    cyc(3);
    check(internal_reset_out, 1'b1);
    i_osc.pulses(1'b1, 512);
    cyc(2);
    await_osc(6);
    count(64);
    check(n_core, 64);
    start(4'hC, 2'h0, 1'b1, 512, 272);
    @(posedge ref_clk_in);
    sleep_wake_in <= 1'b1;
    @(posedge ref_clk_in);
    sleep_wake_in <= 1'b0;
    cyc(2);
    await_osc(258);
    start(4'h0, 2'h0, 1'b1, 0, 6);
    start(4'h5, 2'h0, 1'b1, 0, 4);
    start(4'hD, 2'h1, 1'b1, 0, 16398);
    finish_test();
  end
endmodule : tb_clock_select_startup_sequencer
